/* bench/pam_addr_map_props.sv */
// concurrent checks on the address decoder ports
module pam_addr_map_props (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // request side
   input wire logic extFitted,
   input wire logic opValid,
   input wire logic [3:0] opArea,
   input wire logic opIsBit,
   input wire logic [15:0] opNumber,
   input wire logic [4:0] opBitNum,
   input wire logic [15:0] memWord,
   input wire logic deviceFlagSet,
   input wire logic deviceFlagValue,
   // result side
   input wire logic resValid,
   input wire logic [15:0] resAddr,
   input wire logic [3:0] resBit,
   input wire logic resError,
   input wire logic [2:0] resErrCode,
   input wire logic [15:0] bitAsValue,
   input wire logic carryFlag
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] upCnt_reg;
   logic armed;
   // the reset release runs through two flops, so hold off until it has passed
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) upCnt_reg <= 2'h0;
      else if (upCnt_reg != 2'h3) upCnt_reg <= upCnt_reg + 2'h1;
   end
   assign armed = upCnt_reg == 2'h3;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_answer_next: assert property (armed && opValid |=> resValid)
      else $error("no result one cycle after request");
   a_result_holds: assert property (armed && !opValid |=> $stable(resAddr) && $stable(resErrCode))
      else $error("result changed without request");
   a_core_io_word: assert property (armed && opValid && opArea == 4'h0 && !opIsBit
      && opNumber <= 16'h09fb |=> !resError && resAddr == $past(opNumber))
      else $error("core io word address wrong");
   a_flag_split: assert property (armed && opValid && opArea == 4'h4 && opIsBit
      && opNumber <= 16'h03ff
      |=> resAddr == (16'h0d00 | ($past(opNumber) >> 4)) && resBit == $past(opNumber[3:0]))
      else $error("transition flag address wrong");
   a_word_only: assert property (armed && opValid && opArea == 4'h8 && opIsBit
      |=> resError && resErrCode == 3'h2)
      else $error("bit access to data memory accepted");
   a_bit_only: assert property (armed && opValid && opArea inside {4'h4, 4'h5} && !opIsBit
      |=> resErrCode == 3'h3)
      else $error("word access to flag area accepted");
   a_bit_field: assert property (armed && opValid && opArea == 4'h0 && opIsBit
      && opBitNum > 5'h0f |=> resErrCode == 3'h4)
      else $error("bit field above 15 accepted");
   a_ext_absent: assert property (armed && opValid && opArea == 4'h9 && !extFitted
      |=> resError && resErrCode == 3'h5)
      else $error("extended memory used while absent");
   a_bit_value: assert property (armed && resValid |=> bitAsValue == {15'h0, $past(memWord[resBit])})
      else $error("bit value wrong");
   a_carry_device: assert property (armed && deviceFlagSet |=> carryFlag == $past(deviceFlagValue))
      else $error("device carry update lost");
   c_ext_access: cover property (opValid && opArea == 4'h9 && extFitted);
   c_back_to_back: cover property (opValid ##1 opValid);
   c_error_answer: cover property (resValid && resError);
endmodule

/* bench/pam_fetch_model.sv */
// operand fetch side: memory word returned for the decoded address
module pam_fetch_model (
   // decoded address
   input wire logic [15:0] resAddr,
   // sixteen bit word handed back
   output logic [15:0] memWord
);
   timeunit 1ns;
   timeprecision 1ns;
   // scrambled so that neighbouring addresses give differing bits
   assign memWord = {resAddr[7:0] ^ 8'h5a, resAddr[15:8] ^ 8'hc3};
endmodule

/* bench/testbench.sv */
// self-checking bench for the data area address decoder
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin errors++; \
   $display("MISMATCH at %0t ns: got %h expected %h", $time, got, exp); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [3:0] area;
      logic isBit;
      logic [15:0] num;
      logic [4:0] bitNum;
      logic [3:0] xb;
      logic [15:0] eAddr;
      logic [3:0] eBit;
      logic [2:0] eReg;
      logic [2:0] eErr;
   } pam_row_t;
   logic clk, nrst, extFitted, opValid, opIsBit, userFlagWrite, userFlagValue, deviceFlagSet, deviceFlagValue;
   logic [3:0] opArea;
   logic [15:0] opNumber, memWord, resAddr, bitAsValue;
   logic [4:0] opBitNum;
   logic [2:0] opBank, resBank, resErrCode;
   logic resValid, resIsBit, resRegAccess, resError, carryFlag;
   logic [3:0] resBit;
   logic [1:0] resRegNum;
   int errors, testsRun;
   // xb holds {fitted, bank}; area 0 is bare core io
   pam_row_t rows [28] = '{
      '{4'h0, 1'b0, 16'h09fb, 5'h00, 4'h0, 16'h09fb, 4'h0, 3'h0, 3'h0},
      '{4'h0, 1'b1, 16'h000c, 5'h0f, 4'h0, 16'h000c, 4'hf, 3'h0, 3'h0},
      '{4'h0, 1'b1, 16'h09fc, 5'h00, 4'h0, 16'h0000, 4'h0, 3'h0, 3'h1},
      '{4'h0, 1'b1, 16'h000c, 5'h10, 4'h0, 16'h0000, 4'h0, 3'h0, 3'h4},
      '{4'h1, 1'b1, 16'h0007, 5'h00, 4'h0, 16'h09ff, 4'h7, 3'h0, 3'h0},
      '{4'h2, 1'b0, 16'h00ff, 5'h00, 4'h0, 16'h0aff, 4'h0, 3'h0, 3'h0},
      '{4'h3, 1'b1, 16'h01ff, 5'h03, 4'h0, 16'h0cff, 4'h3, 3'h0, 3'h0},
      '{4'h4, 1'b1, 16'h03ff, 5'h00, 4'h0, 16'h0d3f, 4'hf, 3'h0, 3'h0},
      '{4'h4, 1'b0, 16'h0005, 5'h00, 4'h0, 16'h0000, 4'h0, 3'h0, 3'h3},
      '{4'h5, 1'b1, 16'h03ff, 5'h00, 4'h0, 16'h0e3f, 4'hf, 3'h0, 3'h0},
      '{4'h6, 1'b1, 16'h03ff, 5'h00, 4'h0, 16'h0f3f, 4'hf, 3'h0, 3'h0},
      '{4'h6, 1'b0, 16'h03ff, 5'h00, 4'h0, 16'h13ff, 4'h0, 3'h0, 3'h0},
      '{4'h7, 1'b1, 16'h0000, 5'h00, 4'h0, 16'h0f80, 4'h0, 3'h0, 3'h0},
      '{4'h7, 1'b0, 16'h03ff, 5'h00, 4'h0, 16'h1bff, 4'h0, 3'h0, 3'h0},
      '{4'h8, 1'b0, 16'h5fff, 5'h00, 4'h0, 16'h7fff, 4'h0, 3'h0, 3'h0},
      '{4'h8, 1'b1, 16'h0000, 5'h00, 4'h0, 16'h0000, 4'h0, 3'h0, 3'h2},
      '{4'h9, 1'b0, 16'h0ffd, 5'h00, 4'h9, 16'h8ffd, 4'h0, 3'h0, 3'h0},
      '{4'h9, 1'b0, 16'h0000, 5'h00, 4'h1, 16'h0000, 4'h0, 3'h0, 3'h5},
      '{4'ha, 1'b0, 16'h0002, 5'h00, 4'h0, 16'h0000, 4'h0, 3'h6, 3'h0},
      '{4'hc, 1'b0, 16'h1234, 5'h00, 4'h0, 16'h1234, 4'h0, 3'h0, 3'h0},
      '{4'hd, 1'b0, 16'h0000, 5'h00, 4'h0, 16'h0000, 4'h0, 3'h0, 3'h6},
      '{4'h9, 1'b0, 16'h0000, 5'h00, 4'ha, 16'h0000, 4'h0, 3'h0, 3'h5},
      '{4'h9, 1'b0, 16'h0ffe, 5'h00, 4'h8, 16'h0000, 4'h0, 3'h0, 3'h1},
      '{4'hb, 1'b0, 16'h0001, 5'h00, 4'h0, 16'h0000, 4'h0, 3'h5, 3'h0},
      '{4'hc, 1'b0, 16'h09fd, 5'h00, 4'h0, 16'h0000, 4'h0, 3'h0, 3'h1},
      '{4'hc, 1'b0, 16'h8000, 5'h00, 4'h8, 16'h8000, 4'h0, 3'h0, 3'h0},
      '{4'h1, 1'b0, 16'h0003, 5'h00, 4'h0, 16'h0000, 4'h0, 3'h0, 3'h3},
      '{4'h4, 1'b1, 16'h0010, 5'h1f, 4'h0, 16'h0d01, 4'h0, 3'h0, 3'h0}};
   pam_addr_map #(.LARGE_MODEL(1'b1), .EXT_BANKS(2)) pam_addr_map_i (.clk(clk), .nrst(nrst), .extFitted(extFitted),
      .opValid(opValid), .opArea(opArea), .opIsBit(opIsBit), .opNumber(opNumber), .opBitNum(opBitNum),
      .opBank(opBank), .memWord(memWord), .userFlagWrite(userFlagWrite), .userFlagValue(userFlagValue),
      .deviceFlagSet(deviceFlagSet), .deviceFlagValue(deviceFlagValue), .resValid(resValid), .resAddr(resAddr),
      .resBit(resBit), .resIsBit(resIsBit), .resBank(resBank), .resRegAccess(resRegAccess), .resRegNum(resRegNum),
      .resError(resError), .resErrCode(resErrCode), .bitAsValue(bitAsValue), .carryFlag(carryFlag));
   pam_fetch_model pam_fetch_model_i (.resAddr(resAddr), .memWord(memWord));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", testsRun, errors);
      if (errors == 0 && testsRun > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic drive(input pam_row_t r);
      opArea = r.area;
      opIsBit = r.isBit;
      opNumber = r.num;
      opBitNum = r.bitNum;
      extFitted = r.xb[3];
      opBank = r.xb[2:0];
      opValid = 1'b1;
   endtask
   task automatic run_row(input pam_row_t r);
      logic [15:0] pat;
      @(negedge clk);
      drive(r);
      @(negedge clk);
      opValid = 1'b0;
      `CHK(resValid, 1'b1)
      `CHK({resError, resErrCode}, {r.eErr != 3'h0, r.eErr})
      if (r.eErr == 3'h0) begin
         `CHK({resAddr, resBit, resIsBit}, {r.eAddr, r.eBit, r.isBit})
         `CHK({resBank, resRegAccess, resRegNum}, {r.xb[2:0], r.eReg})
         pat = {r.eAddr[7:0] ^ 8'h5a, r.eAddr[15:8] ^ 8'hc3};
         @(negedge clk);
         `CHK(bitAsValue, {15'h0, pat[r.eBit]})
      end
      $display("row area %h number %h done", r.area, r.num);
   endtask
   initial begin
      {nrst, extFitted, opValid, opIsBit, userFlagWrite, userFlagValue, deviceFlagSet, deviceFlagValue} = 8'h00;
      {opArea, opNumber, opBitNum, opBank} = 28'h0;
      errors = 0;
      testsRun = 0;
      repeat (5) @(negedge clk);
      `CHK({resValid, resAddr, carryFlag}, 18'h0)
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      foreach (rows[i]) run_row(rows[i]);
      @(negedge clk);
      drive(rows[0]);
      @(negedge clk);
      drive(rows[7]);
      `CHK(resAddr, 16'h09fb)
      @(negedge clk);
      opValid = 1'b0;
      `CHK({resValid, resAddr}, {1'b1, 16'h0d3f})
      @(negedge clk);
      `CHK({resValid, resAddr}, {1'b0, 16'h0d3f})
      $display("back to back test done");
      {userFlagWrite, userFlagValue} = 2'h3;
      @(negedge clk);
      `CHK(carryFlag, 1'b1)
      {deviceFlagSet, deviceFlagValue} = 2'h2;
      @(negedge clk);
      `CHK(carryFlag, 1'b0)
      {userFlagWrite, deviceFlagValue} = 2'h1;
      @(negedge clk);
      `CHK(carryFlag, 1'b1)
      deviceFlagSet = 1'b0;
      @(negedge clk);
      `CHK(carryFlag, 1'b1)
      $display("carry flag test done");
      nrst = 1'b0;
      #1;
      `CHK({resValid, resAddr, carryFlag}, 18'h0)
      @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      run_row(rows[1]);
      $display("mid-run reset test done");
      report_and_stop;
   end
   // about 100 cycles expected; 4000 leaves ample margin
   initial begin
      #200000;
      errors++;
      $display("watchdog expired");
      report_and_stop;
   end
endmodule
bind pam_addr_map pam_addr_map_props pam_addr_map_props_i (.clk(clk), .nrst(nrst), .extFitted(extFitted),
   .opValid(opValid), .opArea(opArea), .opIsBit(opIsBit), .opNumber(opNumber), .opBitNum(opBitNum),
   .memWord(memWord), .deviceFlagSet(deviceFlagSet), .deviceFlagValue(deviceFlagValue), .resValid(resValid),
   .resAddr(resAddr), .resBit(resBit), .resError(resError), .resErrCode(resErrCode), .bitAsValue(bitAsValue),
   .carryFlag(carryFlag));

/* logic/pam_addr_map.sv */
// data area operand to memory address decoder with access checks
// How it works
// - core io words 0..2555 at 0000..09fb
// - eight temp relay bits at 09ff
// - bus link words 0..255 at 0a00
// - auxiliary words 0..511 at 0b00
// - transition flags from 0d00, model sized
// - step flags from 0e00, model sized
// - timer done flags 0f00, values 1000
// - counter done flags 0f80, values 1800
// - data memory from 2000, model sized
// - extended banks at 8000..8ffd when fitted
// - three index, three data registers
// - sixteen bit words, bit 00 lsb
// - word only areas reject bit operands
// - flag areas accept bit access only
// - io, link, aux allow both widths
// - bit number above 15 is invalid for io, link, aux and raw
// - status flags updated by device mostly
// - raw address reaches mapped regions only, gaps rejected
// - bit reads as numeric one or zero
module pam_addr_map #(
   parameter bit LARGE_MODEL = 1'b1,
   parameter int EXT_BANKS = 0
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // model straps
   input wire logic extFitted,
   // operand request
   input wire logic opValid,
   input wire logic [3:0] opArea,
   input wire logic opIsBit,
   input wire logic [15:0] opNumber,
   input wire logic [4:0] opBitNum,
   input wire logic [2:0] opBank,
   // bit value extraction and status flag write
   input wire logic [15:0] memWord,
   input wire logic userFlagWrite,
   input wire logic userFlagValue,
   input wire logic deviceFlagSet,
   input wire logic deviceFlagValue,
   // result
   output logic resValid,
   output logic [15:0] resAddr,
   output logic [3:0] resBit,
   output logic resIsBit,
   output logic [2:0] resBank,
   output logic resRegAccess,
   output logic [1:0] resRegNum,
   output logic resError,
   output logic [2:0] resErrCode,
   output logic [15:0] bitAsValue,
   output logic carryFlag
);
   initial begin
      if (EXT_BANKS != 0 && EXT_BANKS != 2 && EXT_BANKS != 4 && EXT_BANKS != 8) begin
         $error("EXT_BANKS must be 0, 2, 4 or 8");
      end
      if (EXT_BANKS != 0 && !LARGE_MODEL) begin
         $error("extended memory needs the large model");
      end
   end

   localparam logic [15:0] FLAG_MAX = LARGE_MODEL ? pam_pkg::LARGE_MAX_NUM : pam_pkg::SMALL_MAX_NUM;
   localparam logic [15:0] DM_LAST = LARGE_MODEL ? pam_pkg::DM_LAST_LARGE : pam_pkg::DM_LAST_SMALL;
   localparam logic [3:0] BANK_COUNT = 4'(EXT_BANKS);
   localparam logic [15:0] FLAG_WORDS = {4'h0, FLAG_MAX[15:4]};
   localparam logic [15:0] TRANS_LAST = LARGE_MODEL ? pam_pkg::TRANS_LAST_LARGE : pam_pkg::TRANS_LAST_SMALL;
   localparam logic [15:0] STEP_LAST = LARGE_MODEL ? pam_pkg::STEP_LAST_LARGE : pam_pkg::STEP_LAST_SMALL;

   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic [3:0] bitNum;
      logic isBit;
      logic [2:0] bank;
      logic regAccess;
      logic [1:0] regNum;
      logic err;
      logic [2:0] errCode;
      logic [15:0] bitValue;
      logic carry;
   } pam_state_t;

   pam_state_t st_reg;
   pam_state_t st_next;
   // release synchroniser kept apart: it resets from the pin, the state from its output
   logic [1:0] rstSync_reg;
   logic rstN;
   assign rstN = rstSync_reg[1];

   logic [15:0] addr;
   logic wordOk;
   logic bitOk;
   logic inRange;
   logic isReg;
   logic [2:0] cause;
   logic [15:0] flagWord;
   logic hasBitField;

   // raw address regions of this model, extended memory last
   localparam int REGIONS = 12;
   localparam logic [15:0] REGION_LO [REGIONS] = '{
      pam_pkg::CORE_IO_BASE,
      pam_pkg::TEMP_RELAY_ADDR,
      pam_pkg::BUS_LINK_BASE,
      pam_pkg::AUX_BASE,
      pam_pkg::TRANS_BASE,
      pam_pkg::STEP_BASE,
      pam_pkg::TIM_DONE_BASE,
      pam_pkg::CNT_DONE_BASE,
      pam_pkg::TIM_PV_BASE,
      pam_pkg::CNT_PV_BASE,
      pam_pkg::DM_BASE,
      pam_pkg::EM_BASE
   };
   localparam logic [15:0] REGION_HI [REGIONS] = '{
      pam_pkg::CORE_IO_LAST_WORD,
      pam_pkg::TEMP_RELAY_ADDR,
      pam_pkg::BUS_LINK_LAST,
      pam_pkg::AUX_LAST,
      TRANS_LAST,
      STEP_LAST,
      pam_pkg::TIM_DONE_BASE + FLAG_WORDS,
      pam_pkg::CNT_DONE_BASE + FLAG_WORDS,
      pam_pkg::TIM_PV_BASE + FLAG_MAX,
      pam_pkg::CNT_PV_BASE + FLAG_MAX,
      DM_LAST,
      pam_pkg::EM_LAST
   };

   initial begin
      for (int r = 0; r < REGIONS; r++) begin
         if (REGION_LO[r] > REGION_HI[r]) begin
            $error("raw address region is empty");
         end
      end
   end

   logic [REGIONS-1:0] regionHit;
   for (genvar r = 0; r < REGIONS; r++) begin : g_region
      assign regionHit[r] = (opNumber >= REGION_LO[r]) && (opNumber <= REGION_HI[r]);
   end
   // gaps between regions answer with a range error rather than a stray word
   logic rawInRange;
   assign rawInRange = (|regionHit[REGIONS-2:0])
      || (regionHit[REGIONS-1] && extFitted && BANK_COUNT != 4'h0);

   always_comb begin
      addr = 16'h0000;
      wordOk = 1'b0;
      bitOk = 1'b0;
      inRange = 1'b0;
      isReg = 1'b0;
      hasBitField = 1'b0;
      flagWord = {4'h0, opNumber[15:4]};
      unique case (opArea)
         pam_pkg::AREA_CORE_IO: begin
            addr = pam_pkg::CORE_IO_BASE + opNumber;
            wordOk = 1'b1;
            bitOk = 1'b1;
            hasBitField = 1'b1;
            inRange = opNumber <= pam_pkg::CORE_IO_MAX_NUM;
         end
         pam_pkg::AREA_TEMP_RELAY: begin
            addr = pam_pkg::TEMP_RELAY_ADDR;
            bitOk = 1'b1;
            inRange = opNumber <= pam_pkg::TEMP_RELAY_MAX;
         end
         pam_pkg::AREA_BUS_LINK: begin
            addr = pam_pkg::BUS_LINK_BASE + opNumber;
            wordOk = 1'b1;
            bitOk = 1'b1;
            hasBitField = 1'b1;
            inRange = opNumber <= pam_pkg::BUS_LINK_MAX_NUM;
         end
         pam_pkg::AREA_AUX: begin
            addr = pam_pkg::AUX_BASE + opNumber;
            wordOk = 1'b1;
            bitOk = 1'b1;
            hasBitField = 1'b1;
            inRange = opNumber <= pam_pkg::AUX_MAX_NUM;
         end
         pam_pkg::AREA_TRANSITION: begin
            // sixteen flags pack into each word
            addr = pam_pkg::TRANS_BASE + flagWord;
            bitOk = 1'b1;
            inRange = opNumber <= FLAG_MAX;
         end
         pam_pkg::AREA_STEP: begin
            addr = pam_pkg::STEP_BASE + flagWord;
            bitOk = 1'b1;
            inRange = opNumber <= FLAG_MAX;
         end
         pam_pkg::AREA_TIMER: begin
            // same number names the value by word or the done flag by bit
            addr = opIsBit ? pam_pkg::TIM_DONE_BASE + flagWord : pam_pkg::TIM_PV_BASE + opNumber;
            wordOk = 1'b1;
            bitOk = 1'b1;
            inRange = opNumber <= FLAG_MAX;
         end
         pam_pkg::AREA_COUNTER: begin
            addr = opIsBit ? pam_pkg::CNT_DONE_BASE + flagWord : pam_pkg::CNT_PV_BASE + opNumber;
            wordOk = 1'b1;
            bitOk = 1'b1;
            inRange = opNumber <= FLAG_MAX;
         end
         pam_pkg::AREA_DATA_MEM: begin
            addr = pam_pkg::DM_BASE + opNumber;
            wordOk = 1'b1;
            inRange = opNumber <= DM_LAST - pam_pkg::DM_BASE;
         end
         pam_pkg::AREA_EXT_MEM: begin
            // bank is carried beside the address, the window repeats per bank
            addr = pam_pkg::EM_BASE + {4'h0, opNumber[11:0]};
            wordOk = 1'b1;
            inRange = opNumber <= pam_pkg::EM_MAX_NUM && opNumber <= pam_pkg::EM_LAST - pam_pkg::EM_BASE;
         end
         pam_pkg::AREA_INDEX_REG, pam_pkg::AREA_DATA_REG: begin
            isReg = 1'b1;
            wordOk = 1'b1;
            inRange = opNumber <= 16'(pam_pkg::REG_MAX);
         end
         pam_pkg::AREA_RAW_ADDR: begin
            addr = opNumber;
            wordOk = 1'b1;
            bitOk = 1'b1;
            hasBitField = 1'b1;
            inRange = rawInRange;
         end
         default: begin
            addr = 16'h0000;
         end
      endcase
   end

   logic extMissing;
   assign extMissing = (opArea == pam_pkg::AREA_EXT_MEM)
      && (!extFitted || BANK_COUNT == 4'h0 || {1'b0, opBank} >= BANK_COUNT);

   always_comb begin
      cause = pam_pkg::ERR_NONE;
      if (opArea > pam_pkg::AREA_RAW_ADDR) begin
         cause = pam_pkg::ERR_AREA;
      end else if (extMissing) begin
         cause = pam_pkg::ERR_NO_EXT;
      end else if (opIsBit && !bitOk) begin
         cause = pam_pkg::ERR_WORD_ONLY;
      end else if (!opIsBit && !wordOk) begin
         cause = pam_pkg::ERR_BIT_ONLY;
      end else if (opIsBit && hasBitField && opBitNum > pam_pkg::BIT_MAX) begin
         cause = pam_pkg::ERR_BIT_NUM;
      end else if (!inRange) begin
         cause = pam_pkg::ERR_RANGE;
      end
   end

   logic [3:0] bitSel;
   always_comb begin
      unique case (opArea)
         pam_pkg::AREA_TEMP_RELAY: bitSel = opNumber[3:0];
         pam_pkg::AREA_TRANSITION, pam_pkg::AREA_STEP, pam_pkg::AREA_TIMER, pam_pkg::AREA_COUNTER: begin
            bitSel = opNumber[3:0];
         end
         default: bitSel = opBitNum[3:0];
      endcase
   end

   always_comb begin
      st_next = st_reg;
      st_next.valid = opValid;
      if (opValid) begin
         st_next.addr = isReg ? 16'h0000 : addr;
         st_next.bitNum = opIsBit ? bitSel : 4'h0;
         st_next.isBit = opIsBit;
         st_next.bank = (opArea == pam_pkg::AREA_EXT_MEM) ? opBank : 3'h0;
         st_next.regAccess = isReg;
         st_next.regNum = isReg ? opNumber[1:0] : 2'h0;
         st_next.err = cause != pam_pkg::ERR_NONE;
         st_next.errCode = cause;
      end
      // extracted bit reads as numeric 0 or 1 on the word selected last
      st_next.bitValue = {15'h0000, memWord[st_reg.bitNum]};
      // device update wins, user may also write the carry
      if (deviceFlagSet) begin
         st_next.carry = deviceFlagValue;
      end else if (userFlagWrite) begin
         st_next.carry = userFlagValue;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstSync_reg <= 2'b00;
      end else begin
         rstSync_reg <= {rstSync_reg[0], 1'b1};
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         st_reg.valid <= 1'b0;
         st_reg.addr <= 16'h0000;
         st_reg.bitNum <= 4'h0;
         st_reg.isBit <= 1'b0;
         st_reg.bank <= 3'h0;
         st_reg.regAccess <= 1'b0;
         st_reg.regNum <= 2'h0;
         st_reg.err <= 1'b0;
         st_reg.errCode <= 3'h0;
         st_reg.bitValue <= 16'h0000;
         st_reg.carry <= 1'b0;
      end else begin
         st_reg.valid <= st_next.valid;
         st_reg.addr <= st_next.addr;
         st_reg.bitNum <= st_next.bitNum;
         st_reg.isBit <= st_next.isBit;
         st_reg.bank <= st_next.bank;
         st_reg.regAccess <= st_next.regAccess;
         st_reg.regNum <= st_next.regNum;
         st_reg.err <= st_next.err;
         st_reg.errCode <= st_next.errCode;
         st_reg.bitValue <= st_next.bitValue;
         st_reg.carry <= st_next.carry;
      end
   end

   assign resValid = st_reg.valid;
   assign resAddr = st_reg.addr;
   assign resBit = st_reg.bitNum;
   assign resIsBit = st_reg.isBit;
   assign resBank = st_reg.bank;
   assign resRegAccess = st_reg.regAccess;
   assign resRegNum = st_reg.regNum;
   assign resError = st_reg.err;
   assign resErrCode = st_reg.errCode;
   assign bitAsValue = st_reg.bitValue;
   assign carryFlag = st_reg.carry;
endmodule

/* logic/pam_pkg.sv */
// constants and types for the data area address decoder
package pam_pkg;
   localparam int WORD_BITS = 16;
   localparam int ADDR_BITS = 16;
   localparam logic [15:0] CORE_IO_BASE = 16'h0000;
   localparam logic [15:0] CORE_IO_LAST_WORD = 16'h09fb;
   localparam logic [15:0] TEMP_RELAY_ADDR = 16'h09ff;
   localparam logic [15:0] BUS_LINK_BASE = 16'h0a00;
   localparam logic [15:0] BUS_LINK_LAST = 16'h0aff;
   localparam logic [15:0] AUX_BASE = 16'h0b00;
   localparam logic [15:0] AUX_LAST = 16'h0cff;
   localparam logic [15:0] TRANS_BASE = 16'h0d00;
   localparam logic [15:0] TRANS_LAST_SMALL = 16'h0d1f;
   localparam logic [15:0] TRANS_LAST_LARGE = 16'h0d3f;
   localparam logic [15:0] STEP_BASE = 16'h0e00;
   localparam logic [15:0] STEP_LAST_SMALL = 16'h0e1f;
   localparam logic [15:0] STEP_LAST_LARGE = 16'h0e3f;
   localparam logic [15:0] TIM_DONE_BASE = 16'h0f00;
   localparam logic [15:0] CNT_DONE_BASE = 16'h0f80;
   localparam logic [15:0] TIM_PV_BASE = 16'h1000;
   localparam logic [15:0] CNT_PV_BASE = 16'h1800;
   localparam logic [15:0] DM_BASE = 16'h2000;
   localparam logic [15:0] DM_LAST_SMALL = 16'h3fff;
   localparam logic [15:0] DM_LAST_LARGE = 16'h7fff;
   localparam logic [15:0] EM_BASE = 16'h8000;
   localparam logic [15:0] EM_LAST = 16'h8ffd;
   localparam logic [15:0] CORE_IO_MAX_NUM = 16'd2555;
   localparam logic [15:0] BUS_LINK_MAX_NUM = 16'd255;
   localparam logic [15:0] AUX_MAX_NUM = 16'd511;
   localparam logic [15:0] SMALL_MAX_NUM = 16'd511;
   localparam logic [15:0] LARGE_MAX_NUM = 16'd1023;
   localparam logic [15:0] EM_MAX_NUM = 16'd32765;
   localparam logic [15:0] TEMP_RELAY_MAX = 16'd7;
   localparam logic [4:0] BIT_MAX = 5'd15;
   localparam logic [1:0] REG_MAX = 2'd2;

   // operand area selector
   typedef enum logic [3:0] {
      AREA_CORE_IO = 4'h0,
      AREA_TEMP_RELAY = 4'h1,
      AREA_BUS_LINK = 4'h2,
      AREA_AUX = 4'h3,
      AREA_TRANSITION = 4'h4,
      AREA_STEP = 4'h5,
      AREA_TIMER = 4'h6,
      AREA_COUNTER = 4'h7,
      AREA_DATA_MEM = 4'h8,
      AREA_EXT_MEM = 4'h9,
      AREA_INDEX_REG = 4'ha,
      AREA_DATA_REG = 4'hb,
      AREA_RAW_ADDR = 4'hc
   } pam_area_t;

   // error cause codes
   typedef enum logic [2:0] {
      ERR_NONE = 3'h0,
      ERR_RANGE = 3'h1,
      ERR_WORD_ONLY = 3'h2,
      ERR_BIT_ONLY = 3'h3,
      ERR_BIT_NUM = 3'h4,
      ERR_NO_EXT = 3'h5,
      ERR_AREA = 3'h6
   } pam_err_t;
endpackage
